// File: core/tci_edge.sv
// synchronisers and edge detectors for the capture pins
// assumes pins are asynchronous to sys_clk
`timescale 1ns/1ps
module tci_edge
  import tci_pkg::*;
#(
  parameter int CH = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pins, index 0 is pin zero
  input wire logic [CH-1:0] pin,
  input wire logic [2*CH-1:0] mode,
  // one-cycle capture events
  output logic [CH-1:0] hit
);
  genvar i;
  generate
    for (i = 0; i < CH; i++) begin : g_ch
      logic s1_q, s2_q, s3_q, lvl_q;
      logic [1:0] m;
      assign m = mode[2*i+1:2*i];
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= pin[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      // level only moves when two stages agree, so glitches do not capture
      assign hit[i] = (s2_q == s3_q) && (s3_q != lvl_q) &&
        ((m == EDGE_BOTH) || (m == EDGE_RISE && s3_q) ||
         (m == EDGE_FALL && !s3_q));
    end
  endgenerate
endmodule // tci_edge

// File: core/tci_pkg.sv
// constants, register map and types of the timer input-capture block
// assumes a 100 MHz sys_clk standing in for the bus E clock
//
// Notes on behaviour
// - counter prescaler divides the bus clock by 1, 4, 8 or 16
// - prescaler select accepted once, only within 64 cycles after reset
// - count reads never disturb the counter
// - 16-bit count cleared on reset, read-only, wraps every 65,536 ticks
// - wrap flag sets when count passes from all ones to zero
// - wrap interrupt requested while wrap flag and its enable are both one
// - three capture registers plus one shared capture/compare register
// - capture registers hold no reset value
// - selected pin edge copies current count into that channel's register
// - channels four to one come from pins three to zero
// - shared channel captures only when select bit is one; compare by default
// - pin three direction bit clears on reset, pin starts as input
// - with pin three driven and capture four on, port writes make captures
// - writes to shared register ignored while it acts as capture four
// - edge field: 00 off, 01 rising, 10 falling, 11 both
// - edge fields in one byte, reset zero; 7-6 ch4, 5-4 ch1, 3-2 ch2, 1-0 ch3
// - timer stops in wait mode when interrupts masked and watchdog off
// - capture flag sets on active edge; cleared by writing one
// - capture interrupt requested while flag and its enable are both one
package tci_pkg;
  localparam int CNT_W = 16;
  localparam int PRE_LIMIT = 64;
  localparam logic [7:0] IDX_PORT_DATA = 8'h00;
  localparam logic [7:0] IDX_COUNT = 8'h0e;
  localparam logic [7:0] IDX_CAP_ONE = 8'h10;
  localparam logic [7:0] IDX_CAP_TWO = 8'h12;
  localparam logic [7:0] IDX_CAP_THREE = 8'h14;
  localparam logic [7:0] IDX_SHARED = 8'h1e;
  localparam logic [7:0] IDX_EDGE_CTL = 8'h21;
  localparam logic [7:0] IDX_MASK_FIRST = 8'h22;
  localparam logic [7:0] IDX_FLAG_FIRST = 8'h23;
  localparam logic [7:0] IDX_MASK_SECOND = 8'h24;
  localparam logic [7:0] IDX_FLAG_SECOND = 8'h25;
  localparam logic [7:0] IDX_PORT_CTL = 8'h26;
  // flag/mask first: bit3 shared, bit2 ch1, bit1 ch2, bit0 ch3
  localparam int BIT_SHARED = 3;
  localparam int BIT_WRAP = 7;
  localparam int BIT_DIR3 = 3;
  localparam int BIT_SEL = 2;
  localparam logic [1:0] EDGE_OFF = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
  localparam logic [1:0] EDGE_BOTH = 2'b11;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONES = 16'hffff;
  localparam logic [15:0] SHARED_RST = 16'hffff;
  typedef enum logic [2:0] {
    TCI_IDLE = 3'b001,
    TCI_ACCESS = 3'b010,
    TCI_DONE = 3'b100
  } tci_bus_t;
endpackage

// File: core/tci_pre_if.sv
// carries prescaler control and its tick between timer modules
// assumes one clock domain
`timescale 1ns/1ps
interface tci_pre_if;
  logic run;
  logic [1:0] ratio;
  logic tick;
  modport ctl (output run, output ratio, input tick);
  modport pre (input run, input ratio, output tick);
endinterface

// File: core/tci_prescaler.sv
// prescaler for the free-running count
// assumes run drops while the timer sleeps
`timescale 1ns/1ps
module tci_prescaler
  import tci_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  tci_pre_if.pre pre
);
  logic [3:0] div_q;
  logic [3:0] last;

  always_comb begin
    case (pre.ratio)
      2'd0: last = 4'h0;
      2'd1: last = 4'h3;
      2'd2: last = 4'h7;
      default: last = 4'hf;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !pre.run) begin
      div_q <= 4'h0;
    end else if (div_q >= last) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign pre.tick = pre.run && (div_q >= last);
endmodule // tci_prescaler

// File: core/tci_timer.sv
// timer counter with prescaler and four input-capture channels
// assumes an apb master on sys_clk; wait/mask/watchdog are level inputs
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module tci_timer
  import tci_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // capture pins, bit n is pin n
  input wire logic [3:0] cap_pin,
  output logic pin_three_out,
  output logic pin_three_oe,
  // cpu state
  input wire logic wait_instruction,
  input wire logic irq_masked,
  input wire logic watchdog_enabled,
  // interrupt request
  output logic timer_irq
);
  tci_bus_t bus_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [15:0] free_running_count_q;
  logic [15:0] capture_reg_one_q;
  logic [15:0] capture_reg_two_q;
  logic [15:0] capture_reg_three_q;
  logic [15:0] shared_capture_compare_reg_q;
  logic [7:0] capture_edge_control_q;
  logic [7:0] timer_mask_first_q;
  logic [7:0] timer_flag_first_q;
  logic [7:0] timer_flag_first_d;
  logic count_wrap_irq_enable_q;
  logic [1:0] pre_ratio_q;
  logic pre_locked_q;
  logic [6:0] boot_cnt_q;
  logic ratio_wr;
  logic count_wrap_flag_q;
  logic pin_three_direction_q;
  logic shared_channel_select_q;
  logic port_pin_three_q;
  logic timer_irq_q;
  logic [9:0] idx;
  logic mapped;
  logic wr;
  logic [31:0] rd;
  logic [3:0] hit;
  logic [3:0] pin_src;
  logic [7:0] edge_mode;
  logic [3:0] cap_set;
  logic cmp_hit;
  logic run;
  logic cap_req;
  logic wrap_req;

  tci_pre_if pre_if ();

  // ---- bus
  assign idx = paddr[11:2];
  assign wr = pwrite && psel && penable && pready_q;

  // unmapped and out-of-range indices answer with an error and zero data
  always_comb begin
    mapped = 1'b1;
    rd = 32'h0000_0000;
    case (idx[7:0])
      IDX_PORT_DATA: rd[3] = port_pin_three_q;
      IDX_COUNT: rd[15:0] = free_running_count_q;
      IDX_CAP_ONE: rd[15:0] = capture_reg_one_q;
      IDX_CAP_TWO: rd[15:0] = capture_reg_two_q;
      IDX_CAP_THREE: rd[15:0] = capture_reg_three_q;
      IDX_SHARED: rd[15:0] = shared_capture_compare_reg_q;
      IDX_EDGE_CTL: rd[7:0] = capture_edge_control_q;
      IDX_MASK_FIRST: rd[7:0] = timer_mask_first_q;
      IDX_FLAG_FIRST: rd[7:0] = timer_flag_first_q;
      IDX_MASK_SECOND: rd[7:0] = {count_wrap_irq_enable_q, 5'b00000, pre_ratio_q};
      IDX_FLAG_SECOND: rd[BIT_WRAP] = count_wrap_flag_q;
      IDX_PORT_CTL: begin
        rd[BIT_DIR3] = pin_three_direction_q;
        rd[BIT_SEL] = shared_channel_select_q;
      end
      default: mapped = 1'b0;
    endcase
    if (idx[9:8] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // no wait state: data registered in setup, ready in the first access cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_q <= TCI_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      case (bus_q)
        TCI_IDLE: begin
          if (psel && !penable) begin
            bus_q <= TCI_ACCESS;
            pready_q <= 1'b1;
            pslverr_q <= !mapped;
            prdata_q <= (pwrite || !mapped) ? 32'h0000_0000 : rd;
          end
        end
        TCI_ACCESS: begin
          if (psel && penable) begin
            bus_q <= TCI_DONE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
          end else if (!psel) begin
            // an abandoned transfer must not leave ready stuck high
            bus_q <= TCI_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
          end
        end
        TCI_DONE: begin
          bus_q <= TCI_IDLE;
        end
        default: begin
          bus_q <= TCI_IDLE;
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
        end
      endcase
    end
  end

  // ---- prescaler select, one write inside the boot window
  // the window counter saturates, so the window never reopens
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_cnt_q <= 7'd0;
    end else if (boot_cnt_q != 7'(PRE_LIMIT)) begin
      boot_cnt_q <= boot_cnt_q + 7'd1;
    end
  end

  // window and lock together: a late or second write must not retune the count
  assign ratio_wr = wr && idx[7:0] == IDX_MASK_SECOND && !pre_locked_q &&
                    boot_cnt_q != 7'(PRE_LIMIT);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_ratio_q <= 2'b00;
    end else if (ratio_wr) begin
      pre_ratio_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_locked_q <= 1'b0;
    end else if (ratio_wr) begin
      pre_locked_q <= 1'b1;
    end
  end

  // ---- timebase
  // low-power wait clears prescaler and freezes count; the pins are still watched
  assign run = !(wait_instruction && irq_masked && !watchdog_enabled);
  assign pre_if.run = run;
  assign pre_if.ratio = pre_ratio_q;

  tci_prescaler u_pre (
    .sys_clk(sys_clk),
    .rst(rst),
    .pre(pre_if)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      free_running_count_q <= COUNT_ZERO;
    end else if (pre_if.tick) begin
      free_running_count_q <= free_running_count_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_wrap_flag_q <= 1'b0;
    end else if (pre_if.tick && free_running_count_q == COUNT_ONES) begin
      count_wrap_flag_q <= 1'b1;
    end else if (wr && idx[7:0] == IDX_FLAG_SECOND && pwdata[BIT_WRAP]) begin
      count_wrap_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_wrap_irq_enable_q <= 1'b0;
    end else if (wr && idx[7:0] == IDX_MASK_SECOND) begin
      count_wrap_irq_enable_q <= pwdata[BIT_WRAP];
    end
  end

  // ---- control registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      capture_edge_control_q <= BYTE_ZERO;
    end else if (wr && idx[7:0] == IDX_EDGE_CTL) begin
      capture_edge_control_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_mask_first_q <= BYTE_ZERO;
    end else if (wr && idx[7:0] == IDX_MASK_FIRST) begin
      timer_mask_first_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_three_direction_q <= 1'b0;
    end else if (wr && idx[7:0] == IDX_PORT_CTL) begin
      pin_three_direction_q <= pwdata[BIT_DIR3];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shared_channel_select_q <= 1'b0;
    end else if (wr && idx[7:0] == IDX_PORT_CTL) begin
      shared_channel_select_q <= pwdata[BIT_SEL];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_pin_three_q <= 1'b0;
    end else if (wr && idx[7:0] == IDX_PORT_DATA) begin
      port_pin_three_q <= pwdata[3];
    end
  end

  // ---- capture channels
  // a driven pin three feeds its own data back so port writes capture
  assign pin_src[2:0] = cap_pin[2:0];
  assign pin_src[3] = pin_three_direction_q ? port_pin_three_q : cap_pin[3];
  // regroup the field byte into pin order
  assign edge_mode[1:0] = capture_edge_control_q[5:4];
  assign edge_mode[3:2] = capture_edge_control_q[3:2];
  assign edge_mode[5:4] = capture_edge_control_q[1:0];
  assign edge_mode[7:6] = shared_channel_select_q ?
                          capture_edge_control_q[7:6] : EDGE_OFF;

  tci_edge #(
    .CH(4)
  ) u_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(pin_src),
    .mode(edge_mode),
    .hit(hit)
  );

  // no reset on capture registers, their content is undefined until used
  always_ff @(posedge sys_clk) begin
    if (hit[0]) begin
      capture_reg_one_q <= free_running_count_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (hit[1]) begin
      capture_reg_two_q <= free_running_count_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (hit[2]) begin
      capture_reg_three_q <= free_running_count_q;
    end
  end

  // shared register: capture four or compare five
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shared_capture_compare_reg_q <= SHARED_RST;
    end else if (shared_channel_select_q) begin
      if (hit[3]) begin
        shared_capture_compare_reg_q <= free_running_count_q;
      end
    end else if (wr && idx[7:0] == IDX_SHARED) begin
      shared_capture_compare_reg_q <= pwdata[15:0];
    end
  end

  // match only on a tick, so a slow prescaler does not flag the same count twice
  assign cmp_hit = !shared_channel_select_q && pre_if.tick &&
                   free_running_count_q == shared_capture_compare_reg_q;

  // flag first in register order: shared, ch1, ch2, ch3
  assign cap_set = {hit[3] | cmp_hit, hit[0], hit[1], hit[2]};

  always_comb begin
    timer_flag_first_d = timer_flag_first_q;
    if (wr && idx[7:0] == IDX_FLAG_FIRST) begin
      timer_flag_first_d = timer_flag_first_q & ~pwdata[7:0];
    end
    // a new edge in the clearing cycle is kept
    timer_flag_first_d[3:0] = timer_flag_first_d[3:0] | cap_set;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_flag_first_q <= BYTE_ZERO;
    end else begin
      timer_flag_first_q <= timer_flag_first_d;
    end
  end

  // ---- outputs
  assign cap_req = |(timer_flag_first_q[3:0] & timer_mask_first_q[3:0]);
  assign wrap_req = count_wrap_flag_q && count_wrap_irq_enable_q;

  // registered so the request pin never glitches while flags are cleared
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_irq_q <= 1'b0;
    end else begin
      timer_irq_q <= cap_req || wrap_req;
    end
  end

  assign timer_irq = timer_irq_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pin_three_out = port_pin_three_q;
  assign pin_three_oe = pin_three_direction_q;
endmodule // tci_timer

// File: sim/tb.sv
// self-checking bench for the timer block
// assumes one 100 MHz clock and the pin model on the capture pins
`timescale 1ns/1ps
module tb;
  import tci_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] lvl = 4'h0;
  logic [3:0] cap_pin;
  logic pin_three_out;
  logic pin_three_oe;
  logic wait_instruction = 1'b0;
  logic irq_masked = 1'b0;
  logic watchdog_enabled = 1'b0;
  logic timer_irq;
  logic [31:0] rd;
  logic slv;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t0;
  logic [31:0] dd;
  int dc;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  tci_timer DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_pin(cap_pin), .pin_three_out(pin_three_out),
    .pin_three_oe(pin_three_oe), .wait_instruction(wait_instruction),
    .irq_masked(irq_masked), .watchdog_enabled(watchdog_enabled), .timer_irq(timer_irq));
  tci_pin_model u_pins (.sys_clk(sys_clk), .lvl(lvl), .pin_three_out(pin_three_out),
    .pin_three_oe(pin_three_oe), .cap_pin(cap_pin));
  task automatic final_report();
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge sys_clk);
    t0 = cyc;
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      final_report();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    tick(6);
    rst <= 1'b0;
  endtask
  // count advance between two reads, in counts and in cycles
  task automatic meas();
    logic [15:0] c0;
    int k0;
    apb(0, IDX_COUNT, 0);
    c0 = rd[15:0];
    k0 = t0;
    tick(150);
    apb(0, IDX_COUNT, 0);
    dd = 16'(rd[15:0] - c0);
    dc = t0 - k0;
  endtask
  task automatic t_reset_vals();
    do_reset();
    apb(0, IDX_EDGE_CTL, 0);
    check(rd[7:0], BYTE_ZERO);
    apb(0, IDX_PORT_CTL, 0);
    check(rd[7:0], BYTE_ZERO);
    apb(0, IDX_SHARED, 0);
    check(rd[15:0], SHARED_RST);
    check(pin_three_oe, 1'b0);
    apb(1, IDX_EDGE_CTL, 32'h0000_00a5);
    apb(0, IDX_EDGE_CTL, 0);
    check(rd[7:0], 8'ha5);
    apb(0, 8'h3f, 0);
    check(slv, 1'b1);
  endtask
  // late says the ratio write comes after the acceptance window
  task automatic t_prescale(input logic [1:0] r, input logic late);
    int div;
    do_reset();
    if (late) tick(70);
    apb(1, IDX_MASK_SECOND, {30'd0, r});
    div = late ? 1 : (r == 2'd0 ? 1 : 2 << r);
    meas();
    check(dd >= dc / div && dd <= dc / div + 1, 1'b1);
    apb(1, IDX_MASK_SECOND, {30'd0, ~r});
    meas();
    check(dd >= dc / div && dd <= dc / div + 1, 1'b1);
  endtask
  task automatic t_wait();
    wait_instruction <= 1'b1;
    irq_masked <= 1'b1;
    meas();
    check(dd, 0);
    watchdog_enabled <= 1'b1;
    meas();
    check(dd, dc);
    wait_instruction <= 1'b0;
  endtask
  task automatic t_wrap();
    int n;
    do_reset();
    apb(1, IDX_MASK_SECOND, 32'h0000_0080);
    check(timer_irq, 1'b0);
    n = 0;
    while (timer_irq !== 1'b1 && n < 70000) begin
      tick(1);
      n++;
    end
    check(timer_irq, 1'b1);
    if (timer_irq !== 1'b1) final_report();
    apb(0, IDX_FLAG_SECOND, 0);
    check(rd[BIT_WRAP], 1'b1);
    apb(0, IDX_COUNT, 0);
    check(rd[15:0] < 16'h0020, 1'b1);
    apb(1, IDX_FLAG_SECOND, 32'h0000_0080);
    tick(2);
    check(timer_irq, 1'b0);
  endtask
  task automatic t_capture(input int ch, input logic [1:0] mode);
    int sh;
    int fb;
    logic [7:0] ci;
    logic [15:0] c0;
    sh = (ch == 3) ? 6 : 4 - 2 * ch;
    fb = (ch == 3) ? 3 : 2 - ch;
    ci = (ch == 3) ? IDX_SHARED : IDX_CAP_ONE + 8'(2 * ch);
    apb(1, IDX_EDGE_CTL, 32'(mode) << sh);
    apb(1, IDX_MASK_FIRST, 32'h0000_000f);
    apb(1, IDX_FLAG_FIRST, 32'h0000_000f);
    apb(0, IDX_COUNT, 0);
    c0 = rd[15:0];
    lvl[ch] <= 1'b1;
    tick(8);
    apb(0, IDX_FLAG_FIRST, 0);
    check(rd[fb], mode[0]);
    check(timer_irq, mode[0]);
    if (mode[0]) begin
      apb(0, ci, 0);
      check(rd[15:0] > c0 && rd[15:0] < c0 + 16'h0020, 1'b1);
    end
    apb(1, IDX_FLAG_FIRST, 32'(1) << fb);
    apb(0, IDX_FLAG_FIRST, 0);
    check(rd[fb], 1'b0);
    lvl[ch] <= 1'b0;
    tick(8);
    apb(0, IDX_FLAG_FIRST, 0);
    check(rd[fb], mode[1]);
  endtask
  task automatic t_shared();
    logic [15:0] v;
    apb(0, IDX_SHARED, 0);
    v = rd[15:0];
    apb(1, IDX_SHARED, 32'h0000_1234);
    apb(0, IDX_SHARED, 0);
    check(rd[15:0], v);
    apb(1, IDX_PORT_CTL, 32'h0000_0008 | 32'h0000_0004);
    apb(1, IDX_EDGE_CTL, 32'h0000_00c0);
    apb(1, IDX_FLAG_FIRST, 32'h0000_000f);
    check(pin_three_oe, 1'b1);
    apb(1, IDX_PORT_DATA, 32'h0000_0008);
    tick(8);
    check(pin_three_out, 1'b1);
    apb(0, IDX_FLAG_FIRST, 0);
    check(rd[BIT_SHARED], 1'b1);
    apb(1, IDX_PORT_CTL, 0);
    apb(1, IDX_SHARED, 32'h0000_1234);
    apb(0, IDX_SHARED, 0);
    check(rd[15:0], 16'h1234);
    apb(0, IDX_COUNT, 0);
    v = rd[15:0] + 16'h0040;
    apb(1, IDX_SHARED, {16'h0000, v});
    apb(1, IDX_FLAG_FIRST, 32'h0000_000f);
    apb(0, IDX_FLAG_FIRST, 0);
    check(rd[BIT_SHARED], 1'b0);
    tick(80);
    apb(0, IDX_FLAG_FIRST, 0);
    check(rd[BIT_SHARED], 1'b1);
  endtask
  initial begin
    t_reset_vals();
    for (int r = 0; r < 4; r++) t_prescale(2'(r), 1'b0);
    t_prescale(2'd3, 1'b1);
    t_wait();
    t_wrap();
    apb(1, IDX_PORT_CTL, 32'(1) << BIT_SEL);
    for (int ch = 0; ch < 4; ch++) begin
      for (int m = 0; m < 4; m++) t_capture(ch, 2'(m));
    end
    t_shared();
    final_report();
  end
endmodule // tb

// File: sim/tci_pin_model.sv
// external devices driving the capture pins
// assumes the bench sets the wanted levels on lvl
`timescale 1ns/1ps
module tci_pin_model (
  // clock
  input wire logic sys_clk,
  // wanted levels and pin three driver
  input wire logic [3:0] lvl,
  input wire logic pin_three_out,
  input wire logic pin_three_oe,
  // resolved pin levels
  output logic [3:0] cap_pin
);
  initial cap_pin = 4'h0;
  // pins move just after an edge; a driven pin three follows the port data
  always @(posedge sys_clk) begin
    cap_pin[2:0] <= lvl[2:0];
    cap_pin[3] <= pin_three_oe ? pin_three_out : lvl[3];
  end
endmodule // tci_pin_model

// File: sim/tci_timer_props.sv
// checker for the timer block, sees the top ports only
// assumes the apb master leaves an idle cycle between transfers
`timescale 1ns/1ps
module tci_timer_props
  import tci_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pin and interrupt
  input wire logic pin_three_out,
  input wire logic pin_three_oe,
  input wire logic timer_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic wr_done;
  assign wr_done = psel && penable && pwrite && pready;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_answer)
    else $error("ready missing after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_stands: assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("read data moved outside setup");
  a_out_from_write: assert property ($changed(pin_three_out) |-> $past(wr_done))
    else $error("pin data moved without write");
  a_oe_from_write: assert property ($changed(pin_three_oe) |-> $past(wr_done))
    else $error("pin direction moved without write");
  a_irq_fall_write: assert property ($fell(timer_irq) |-> $past(wr_done, 2))
    else $error("irq dropped without write");
  a_irq_low_reset: assert property ($fell(rst) |-> !timer_irq ##1 !timer_irq)
    else $error("irq high right after reset");
endmodule // tci_timer_props
bind tci_timer tci_timer_props u_props (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_three_out(pin_three_out), .pin_three_oe(pin_three_oe),
  .timer_irq(timer_irq));
